// File: rtl/tsrm_pkg.sv
// constants, field layout and state types of the temperature sensor register bank
// Summary of operation
// R1: setup bit 2 low lets a local over-shutdown reading pull the shutdown output
// R2: setup bit 0 high needs three remote out-of-limit results in a row
// R3: status is read-only at 02h and clears to zero at reset
// R4: status bit 7 shows conversion busy, bit 2 shows remote diode open
// R5: alarm flags sit at bits 6,5,4,3,1,0 and read one when alarmed
// R6: all alarm flags except busy and open can raise the alert
// R7: host waits one conversion time before reading status after a single shot
// R8: only the low four rate bits are kept; upper bits read zero
// R9: rate code reads at 04h, writes at 0Ah, resets to 08h
// R10: rate code picks the free-running interval, doubling from 0.06 Hz to 32 Hz
// R11: upper limits read 05h/07h, write 0Bh/0Dh, reset 46h; low byte at 13h
// R12: lower limits read 06h/08h, write 0Ch/0Eh, low byte 14h, reset zero
// R13: shutdown limits are signed bytes at 20h local and 19h remote, reset 55h
// R14: shutdown hysteresis is five bits at 21h, resetting to 0Ah
// R15: remote trim bytes at 11h and 12h, read/write, reset zero
// R16: style register at BFh; bit 0 low interrupt mode, high comparator mode
// R17: style register bits 7 to 1 read zero
// R18: fixed maker code readable at FEh
// R19: read-only silicon revision readable at FFh
// R20: a write to 0Fh starts one conversion in standby; data is dropped
// R21: reading 0Fh always returns FFh
// R22: after the single conversion the device returns to standby
// R23: eleven-bit values are left-justified; low byte uses its top three bits
// R24: setup bit 7 high masks the alert, low enables it
// R25: setup bit 6 low runs continuously, high is standby with registers usable
// R26: each conversion end compares readings to limits and updates flags
// R27: a remote reading back inside a limit clears its consecutive count
package tsrm_pkg;
  // command codes
  localparam logic [7:0] ADDR_FLAGS_RD  = 8'h02;
  localparam logic [7:0] ADDR_SETUP_RD  = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD   = 8'h04;
  localparam logic [7:0] ADDR_LUP_RD    = 8'h05;
  localparam logic [7:0] ADDR_LLO_RD    = 8'h06;
  localparam logic [7:0] ADDR_RUPH_RD   = 8'h07;
  localparam logic [7:0] ADDR_RLOH_RD   = 8'h08;
  localparam logic [7:0] ADDR_SETUP_WR  = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR   = 8'h0A;
  localparam logic [7:0] ADDR_LUP_WR    = 8'h0B;
  localparam logic [7:0] ADDR_LLO_WR    = 8'h0C;
  localparam logic [7:0] ADDR_RUPH_WR   = 8'h0D;
  localparam logic [7:0] ADDR_RLOH_WR   = 8'h0E;
  localparam logic [7:0] ADDR_SHOT      = 8'h0F;
  localparam logic [7:0] ADDR_TRIMH     = 8'h11;
  localparam logic [7:0] ADDR_TRIML     = 8'h12;
  localparam logic [7:0] ADDR_RUPL      = 8'h13;
  localparam logic [7:0] ADDR_RLOL      = 8'h14;
  localparam logic [7:0] ADDR_RSHUT     = 8'h19;
  localparam logic [7:0] ADDR_LSHUT     = 8'h20;
  localparam logic [7:0] ADDR_HYST      = 8'h21;
  localparam logic [7:0] ADDR_STYLE     = 8'hBF;
  localparam logic [7:0] ADDR_MAKER     = 8'hFE;
  localparam logic [7:0] ADDR_REV       = 8'hFF;
  // setup bits
  localparam int SETUP_MASK_BIT  = 7;
  localparam int SETUP_STOP_BIT  = 6;
  localparam int SETUP_RSHUT_BIT = 4;
  localparam int SETUP_LSHUT_BIT = 2;
  localparam int SETUP_QUEUE_BIT = 0;
  // status bits
  localparam int FLG_BUSY  = 7;
  localparam int FLG_LHI   = 6;
  localparam int FLG_LLO   = 5;
  localparam int FLG_RHI   = 4;
  localparam int FLG_RLO   = 3;
  localparam int FLG_OPEN  = 2;
  localparam int FLG_RSHUT = 1;
  localparam int FLG_LSHUT = 0;
  localparam logic [7:0] ALARM_BITS = 8'h7B;
  // reset values and fixed read values
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [3:0] RST_RATE  = 4'h8;
  localparam logic [7:0] RST_UPPER = 8'h46;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] RST_SHUT  = 8'h55;
  localparam logic [4:0] RST_HYST  = 5'h0A;
  localparam logic [7:0] READ_SHOT = 8'hFF;
  localparam logic [7:0] READ_NONE = 8'h00;
  // rate code limit and queue length
  localparam logic [3:0] RATE_MAX  = 4'h9;
  localparam logic [1:0] QUEUE_LEN = 2'h3;
  // timing
  localparam longint CLK_HZ         = 20000000;
  localparam longint CONV_TIME_US   = 38000;
  localparam longint FAST_PERIOD_US = 31250;
  localparam int CONV_CYC = int'((CONV_TIME_US * CLK_HZ + 999999) / 1000000);
  localparam int FAST_CYC = int'((FAST_PERIOD_US * CLK_HZ) / 1000000);

  typedef enum logic [1:0] {
    TSRM_WAIT = 2'b00,
    TSRM_CONV = 2'b01
  } tsrm_state_t;

  typedef struct packed {
    logic [7:0] upHi;
    logic [2:0] upLo;
    logic [7:0] loHi;
    logic [2:0] loLo;
  } tsrm_limits_t;
endpackage : tsrm_pkg

// File: rtl/tsrm_regbank.sv
// register bank, conversion sequencer and limit checks of the temperature sensor
`timescale 1ns/10ps
module tsrm_regbank #(
  parameter int         CONV_TICKS = tsrm_pkg::CONV_CYC,
  parameter int         FAST_TICKS = tsrm_pkg::FAST_CYC,
  parameter logic [7:0] MAKER_ID   = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION   = 8'h00
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register access
  input  wire logic [7:0]  cmdCode,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [7:0]  rdData,
  output logic             rdValid,
  // converter side
  input  wire logic [10:0] localReading,
  input  wire logic [10:0] remoteReading,
  input  wire logic        diodeOpen,
  output logic             convStart,
  output logic             convBusy,
  // alarm pins
  output logic             alertOut_n,
  output logic             shutdown_out_n
);

  // all state in one struct, so every pin comes from this one register
  typedef struct packed {
    tsrm_pkg::tsrm_state_t  state;
    logic                   busy;
    logic [31:0]            cnt;
    logic                   single;
    logic [7:0]             setup;
    logic [7:0]             flags;
    logic [7:0]             cond;
    logic [3:0]             rate;
    logic [7:0]             locUp;
    logic [7:0]             locLo;
    tsrm_pkg::tsrm_limits_t rem;
    logic [7:0]             remShut;
    logic [7:0]             locShut;
    logic [4:0]             hyst;
    logic [7:0]             trimHi;
    logic [2:0]             trimLo;
    logic                   style;
    logic [1:0]             qHi;
    logic [1:0]             qLo;
    logic [1:0]             qShut;
    logic                   locShutAct;
    logic                   remShutAct;
    logic [7:0]             rdData;
    logic                   rdValid;
    logic                   convStart;
    logic                   alertN;
    logic                   shutN;
  } tsrm_regs_t;

  tsrm_regs_t q_r;
  tsrm_regs_t q_nxt;

  // signed eleven-bit greater-than
  function automatic logic tsrmGt(input logic [10:0] a, input logic [10:0] b);
    tsrmGt = $signed(a) > $signed(b);
  endfunction : tsrmGt

  // interval of the free-running mode; undefined codes run at the fastest rate
  function automatic logic [31:0] tsrmInterval(input logic [3:0] code);
    logic [3:0] c;
    c = (code > tsrm_pkg::RATE_MAX) ? tsrm_pkg::RATE_MAX : code;
    tsrmInterval = 32'(FAST_TICKS) << (tsrm_pkg::RATE_MAX - c);  // see R10
  endfunction : tsrmInterval

  // saturating consecutive out-of-limit count
  function automatic logic [1:0] tsrmQueue(input logic outside, input logic [1:0] n);
    if (!outside) begin
      tsrmQueue = 2'h0;  // see R27
    end else if (n == tsrm_pkg::QUEUE_LEN) begin
      tsrmQueue = n;
    end else begin
      tsrmQueue = n + 2'h1;
    end
  endfunction : tsrmQueue

  // conversion running
  function automatic logic tsrmBusy(input tsrm_pkg::tsrm_state_t s);
    tsrmBusy = s == tsrm_pkg::TSRM_CONV;
  endfunction : tsrmBusy

  // one-degree byte onto the eleven-bit eighth-degree scale
  function automatic logic [10:0] tsrmWiden(input logic [7:0] b);
    tsrmWiden = {b, 3'h0};  // see R13, R23
  endfunction : tsrmWiden

  // upper byte and top three bits of the lower byte as one word
  function automatic logic [10:0] tsrmJoin(input logic [7:0] hi, input logic [2:0] lo);
    tsrmJoin = {hi, lo};  // see R23
  endfunction : tsrmJoin

  // lower byte as read back; the five unused bits read zero
  function automatic logic [7:0] tsrmLowByte(input logic [2:0] lo);
    tsrmLowByte = {lo, 5'h00};  // see R23
  endfunction : tsrmLowByte

  // a remote result only counts once the queue, if enabled, is full
  function automatic logic tsrmQualify(input logic on, input logic [1:0] n, input logic raw);
    tsrmQualify = on ? (n == tsrm_pkg::QUEUE_LEN) : raw;  // see R2
  endfunction : tsrmQualify

  // trips above the limit, releases at or below limit less hysteresis
  function automatic logic tsrmShutHold(input logic trip, input logic act,
                                        input logic [10:0] rdg, input logic [10:0] lim,
                                        input logic [10:0] hyst);
    tsrmShutHold = trip || (act && tsrmGt(rdg, lim - hyst));  // see R1, R14
  endfunction : tsrmShutHold

  // active while any alarm bit of the source is set and the mask is clear
  function automatic logic tsrmAlertN(input logic [7:0] src, input logic masked);
    tsrmAlertN = !(|(src & tsrm_pkg::ALARM_BITS) && !masked);  // see R6, R24
  endfunction : tsrmAlertN

  logic [10:0] remCorr;
  logic [10:0] locUpW;
  logic [10:0] locLoW;
  logic [10:0] locShutW;
  logic [10:0] remShutW;
  logic [10:0] remUpW;
  logic [10:0] remLoW;
  logic [10:0] hystW;

  always_comb begin
    // left-justified words, fractional bits in the low three
    remCorr  = remoteReading + tsrmJoin(q_r.trimHi, q_r.trimLo);  // see R15, R23
    locUpW   = tsrmWiden(q_r.locUp);
    locLoW   = tsrmWiden(q_r.locLo);
    locShutW = tsrmWiden(q_r.locShut);
    remShutW = tsrmWiden(q_r.remShut);
    remUpW   = tsrmJoin(q_r.rem.upHi, q_r.rem.upLo);
    remLoW   = tsrmJoin(q_r.rem.loHi, q_r.rem.loLo);
    hystW    = {3'h0, q_r.hyst, 3'h0};
  end

  logic       endConv;
  logic       rOverHi;
  logic       rUnderLo;
  logic       rOverShut;
  logic [1:0] qHiN;
  logic [1:0] qLoN;
  logic [1:0] qShutN;
  logic [7:0] setFlags;
  logic [7:0] condNow;
  logic       queueOn;

  always_comb begin
    endConv   = tsrmBusy(q_r.state) && (q_r.cnt == 32'h0);
    queueOn   = q_r.setup[tsrm_pkg::SETUP_QUEUE_BIT];
    rOverHi   = tsrmGt(remCorr, remUpW);
    rUnderLo  = tsrmGt(remLoW, remCorr);
    rOverShut = tsrmGt(remCorr, remShutW);
    qHiN      = tsrmQueue(rOverHi, q_r.qHi);
    qLoN      = tsrmQueue(rUnderLo, q_r.qLo);
    qShutN    = tsrmQueue(rOverShut, q_r.qShut);
    condNow   = 8'h00;
    condNow[tsrm_pkg::FLG_LHI]   = tsrmGt(localReading, locUpW);  // see R26
    condNow[tsrm_pkg::FLG_LLO]   = tsrmGt(locLoW, localReading);
    condNow[tsrm_pkg::FLG_LSHUT] = tsrmGt(localReading, locShutW);
    // with the queue enabled, remote results pass only once it has seen three in a row
    condNow[tsrm_pkg::FLG_RHI]   = tsrmQualify(queueOn, qHiN, rOverHi);  // see R2
    condNow[tsrm_pkg::FLG_RLO]   = tsrmQualify(queueOn, qLoN, rUnderLo);
    condNow[tsrm_pkg::FLG_RSHUT] = tsrmQualify(queueOn, qShutN, rOverShut);
    condNow[tsrm_pkg::FLG_OPEN]  = diodeOpen;  // see R4
    setFlags  = endConv ? condNow : 8'h00;
  end

  logic wrHit;
  logic rdHit;
  logic shutLocNow;
  logic shutRemNow;

  always_comb begin
    q_nxt          = q_r;
    wrHit          = wrStb;
    rdHit          = rdStb;
    q_nxt.convStart = 1'b0;
    q_nxt.rdValid   = rdHit;

    // register writes
    if (wrHit) begin
      unique case (cmdCode)
        tsrm_pkg::ADDR_SETUP_WR: q_nxt.setup = wrData;
        tsrm_pkg::ADDR_RATE_WR:  q_nxt.rate = wrData[3:0];  // see R8, R9
        tsrm_pkg::ADDR_LUP_WR:   q_nxt.locUp = wrData;  // see R11
        tsrm_pkg::ADDR_RUPH_WR:  q_nxt.rem.upHi = wrData;
        tsrm_pkg::ADDR_RUPL:     q_nxt.rem.upLo = wrData[7:5];  // see R23
        tsrm_pkg::ADDR_LLO_WR:   q_nxt.locLo = wrData;  // see R12
        tsrm_pkg::ADDR_RLOH_WR:  q_nxt.rem.loHi = wrData;
        tsrm_pkg::ADDR_RLOL:     q_nxt.rem.loLo = wrData[7:5];
        tsrm_pkg::ADDR_RSHUT:    q_nxt.remShut = wrData;  // see R13
        tsrm_pkg::ADDR_LSHUT:    q_nxt.locShut = wrData;
        tsrm_pkg::ADDR_HYST:     q_nxt.hyst = wrData[4:0];  // see R14
        tsrm_pkg::ADDR_TRIMH:    q_nxt.trimHi = wrData;  // see R15
        tsrm_pkg::ADDR_TRIML:    q_nxt.trimLo = wrData[7:5];
        tsrm_pkg::ADDR_STYLE:    q_nxt.style = wrData[0];  // see R16
        tsrm_pkg::ADDR_SHOT: begin
          // data is dropped; only honoured while stopped and idle
          if (q_r.setup[tsrm_pkg::SETUP_STOP_BIT] && q_r.state == tsrm_pkg::TSRM_WAIT) begin
            q_nxt.single = 1'b1;  // see R20
          end
        end
        default: ;
      endcase
    end

    // register reads
    if (rdHit) begin
      unique case (cmdCode)
        tsrm_pkg::ADDR_FLAGS_RD: begin
          q_nxt.rdData = {tsrmBusy(q_r.state), q_r.flags[6:0]};  // see R3, R4, R5
        end
        tsrm_pkg::ADDR_SETUP_RD: q_nxt.rdData = q_r.setup;
        tsrm_pkg::ADDR_RATE_RD:  q_nxt.rdData = {4'h0, q_r.rate};  // see R8, R9
        tsrm_pkg::ADDR_LUP_RD:   q_nxt.rdData = q_r.locUp;  // see R11
        tsrm_pkg::ADDR_RUPH_RD:  q_nxt.rdData = q_r.rem.upHi;
        tsrm_pkg::ADDR_RUPL:     q_nxt.rdData = tsrmLowByte(q_r.rem.upLo);
        tsrm_pkg::ADDR_LLO_RD:   q_nxt.rdData = q_r.locLo;  // see R12
        tsrm_pkg::ADDR_RLOH_RD:  q_nxt.rdData = q_r.rem.loHi;
        tsrm_pkg::ADDR_RLOL:     q_nxt.rdData = tsrmLowByte(q_r.rem.loLo);
        tsrm_pkg::ADDR_RSHUT:    q_nxt.rdData = q_r.remShut;  // see R13
        tsrm_pkg::ADDR_LSHUT:    q_nxt.rdData = q_r.locShut;
        tsrm_pkg::ADDR_HYST:     q_nxt.rdData = {3'h0, q_r.hyst};  // see R14
        tsrm_pkg::ADDR_TRIMH:    q_nxt.rdData = q_r.trimHi;  // see R15
        tsrm_pkg::ADDR_TRIML:    q_nxt.rdData = tsrmLowByte(q_r.trimLo);
        tsrm_pkg::ADDR_STYLE:    q_nxt.rdData = {7'h00, q_r.style};  // see R17
        tsrm_pkg::ADDR_MAKER:    q_nxt.rdData = MAKER_ID;  // see R18
        tsrm_pkg::ADDR_REV:      q_nxt.rdData = REVISION;  // see R19
        tsrm_pkg::ADDR_SHOT:     q_nxt.rdData = tsrm_pkg::READ_SHOT;  // see R21
        default:                 q_nxt.rdData = tsrm_pkg::READ_NONE;
      endcase
    end

    // status read clears the sticky flags; a new result in that cycle still lands
    if (rdHit && cmdCode == tsrm_pkg::ADDR_FLAGS_RD) begin
      q_nxt.flags = setFlags;
      if (!q_r.style && |(q_r.flags & tsrm_pkg::ALARM_BITS)) begin
        q_nxt.setup[tsrm_pkg::SETUP_MASK_BIT] = 1'b1;
      end
    end else begin
      q_nxt.flags = q_r.flags | setFlags;
    end
    q_nxt.flags[tsrm_pkg::FLG_BUSY] = 1'b0;
    if (endConv) begin
      // open follows each result, not latched; a status read clears it until the next one
      q_nxt.flags[tsrm_pkg::FLG_OPEN] = condNow[tsrm_pkg::FLG_OPEN];
    end

    // conversion sequencer
    unique case (q_r.state)
      tsrm_pkg::TSRM_WAIT: begin
        if (q_r.cnt != 32'h0) begin
          q_nxt.cnt = q_r.cnt - 32'h1;
        end
        if (q_r.single || (!q_r.setup[tsrm_pkg::SETUP_STOP_BIT] && q_r.cnt == 32'h0)) begin
          q_nxt.state     = tsrm_pkg::TSRM_CONV;  // see R25
          q_nxt.cnt       = 32'(CONV_TICKS - 1);
          q_nxt.convStart = 1'b1;
        end
      end
      tsrm_pkg::TSRM_CONV: begin
        if (endConv) begin
          q_nxt.state  = tsrm_pkg::TSRM_WAIT;
          q_nxt.single = 1'b0;  // see R22
          q_nxt.cnt    = tsrmInterval(q_r.rate);
          q_nxt.cond   = condNow;
          q_nxt.qHi    = qHiN;
          q_nxt.qLo    = qLoN;
          q_nxt.qShut  = qShutN;
        end else begin
          q_nxt.cnt = q_r.cnt - 32'h1;
        end
      end
      default: begin
        // an illegal code drops back to idle
        q_nxt.state = tsrm_pkg::TSRM_WAIT;
        q_nxt.cnt   = 32'h0;
      end
    endcase
    q_nxt.busy = tsrmBusy(q_nxt.state);  // see R4

    // shutdown output with hysteresis on release
    shutLocNow = q_r.locShutAct;
    shutRemNow = q_r.remShutAct;
    if (endConv) begin
      shutLocNow = tsrmShutHold(condNow[tsrm_pkg::FLG_LSHUT], q_r.locShutAct,
                                localReading, locShutW, hystW);
      shutRemNow = tsrmShutHold(condNow[tsrm_pkg::FLG_RSHUT], q_r.remShutAct,
                                remCorr, remShutW, hystW);
    end
    q_nxt.locShutAct = shutLocNow;
    q_nxt.remShutAct = shutRemNow;
    q_nxt.shutN = !((shutLocNow && !q_nxt.setup[tsrm_pkg::SETUP_LSHUT_BIT]) ||  // see R1
                    (shutRemNow && !q_nxt.setup[tsrm_pkg::SETUP_RSHUT_BIT]));

    // alert: sticky flags in interrupt mode, last result in comparator mode
    if (q_nxt.style) begin  // see R16
      q_nxt.alertN = tsrmAlertN(q_nxt.cond, q_nxt.setup[tsrm_pkg::SETUP_MASK_BIT]);
    end else begin
      q_nxt.alertN = tsrmAlertN(q_nxt.flags, q_nxt.setup[tsrm_pkg::SETUP_MASK_BIT]);
    end
  end

  // synchronous reset; fields not named here reset to zero
  always_ff @(posedge clk) begin
    if (srst) begin
      q_r            <= '0;
      q_r.state      <= tsrm_pkg::TSRM_WAIT;
      q_r.setup      <= tsrm_pkg::RST_SETUP;
      q_r.flags      <= 8'h00;  // see R3
      q_r.rate       <= tsrm_pkg::RST_RATE;  // see R9
      q_r.locUp      <= tsrm_pkg::RST_UPPER;  // see R11
      q_r.rem.upHi   <= tsrm_pkg::RST_UPPER;
      q_r.locLo      <= tsrm_pkg::RST_LOWER;  // see R12
      q_r.rem.loHi   <= tsrm_pkg::RST_LOWER;
      q_r.remShut    <= tsrm_pkg::RST_SHUT;  // see R13
      q_r.locShut    <= tsrm_pkg::RST_SHUT;
      q_r.hyst       <= tsrm_pkg::RST_HYST;  // see R14
      q_r.alertN     <= 1'b1;
      q_r.shutN      <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // pins, each from its own flip-flop
  always_comb begin
    rdData         = q_r.rdData;
    rdValid        = q_r.rdValid;
    convStart      = q_r.convStart;
    convBusy       = q_r.busy;
    alertOut_n     = q_r.alertN;
    shutdown_out_n = q_r.shutN;
  end

endmodule : tsrm_regbank

// File: testbench/tsrm_regbank_asserts.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module tsrm_regbank_asserts #(
  parameter int         CONV_TICKS = 8,
  parameter logic [7:0] MAKER_ID   = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION   = 8'h00
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register access
  input wire logic [7:0]  cmdCode,
  input wire logic [7:0]  wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [7:0]  rdData,
  input wire logic        rdValid,
  // converter side and pins
  input wire logic [10:0] localReading,
  input wire logic [10:0] remoteReading,
  input wire logic        diodeOpen,
  input wire logic        convStart,
  input wire logic        convBusy,
  input wire logic        alertOut_n,
  input wire logic        shutdown_out_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  int busyCnt_r;
  // length of the running conversion, zero while idle
  always_ff @(posedge clk) begin
    if (srst || !convBusy) begin
      busyCnt_r <= 0;
    end else begin
      busyCnt_r <= busyCnt_r + 1;
    end
  end
  sequence s_rd(logic [7:0] code);
    rdStb && cmdCode == code;
  endsequence
  property p_rst;
    disable iff (1'b0) srst |=> rdData == 8'h00 && !rdValid && alertOut_n && shutdown_out_n;
  endproperty
  property p_rdvalid;
    1'b1 |=> rdValid == $past(rdStb);
  endproperty
  property p_shot;
    s_rd(8'h0F) |=> rdData == 8'hFF;
  endproperty
  property p_style;
    s_rd(8'hBF) |=> rdData[7:1] == 7'h00;
  endproperty
  property p_rate;
    s_rd(8'h04) |=> rdData[7:4] == 4'h0;
  endproperty
  property p_busybit;
    s_rd(8'h02) |=> rdData[7] == $past(convBusy);
  endproperty
  property p_maker;
    s_rd(8'hFE) |=> rdData == MAKER_ID;
  endproperty
  property p_rev;
    s_rd(8'hFF) |=> rdData == REVISION;
  endproperty
  property p_start;
    convStart |-> convBusy ##1 convBusy;
  endproperty
  property p_busylen;
    $fell(convBusy) |-> busyCnt_r == CONV_TICKS;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  a_rdvalid: assert property (p_rdvalid) else $error("read answer timing wrong");
  a_shot: assert property (p_shot) else $error("single shot read not FF");
  a_style: assert property (p_style) else $error("style upper bits not zero");
  a_rate: assert property (p_rate) else $error("rate upper bits not zero");
  a_busybit: assert property (p_busybit) else $error("busy flag wrong");
  a_maker: assert property (p_maker) else $error("maker code wrong");
  a_rev: assert property (p_rev) else $error("revision wrong");
  a_start: assert property (p_start) else $error("start without busy");
  a_busylen: assert property (p_busylen) else $error("conversion length wrong");
endmodule : tsrm_regbank_asserts

// File: testbench/tsrm_host_model.sv
// register host model driving the command port
`timescale 1ns/10ps
module tsrm_host_model #(
  parameter int CONV_TICKS = 8
) (
  // clock
  input wire logic       clk,
  // command port
  output logic     [7:0] cmdCode,
  output logic     [7:0] wrData,
  output logic           wrStb,
  output logic           rdStb,
  input wire logic [7:0] rdData,
  input wire logic       rdValid
);
  initial begin
    cmdCode = 8'h00;
    wrData  = 8'h00;
    wrStb   = 1'b0;
    rdStb   = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    #1;
    cmdCode = c;
    wrData  = d;
    wrStb   = 1'b1;
    @(posedge clk);
    #1;
    wrStb   = 1'b0;
    cmdCode = ~c;
    wrData  = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    cmdCode = c;
    rdStb   = 1'b1;
    @(posedge clk);
    #1;
    rdStb   = 1'b0;
    cmdCode = ~c;
    d       = rdData;
    v       = rdValid;
  endtask : rd
  // status is only trusted one conversion time after the trigger
  task automatic shot();
    wr(8'h0F, 8'hAA);
    repeat (CONV_TICKS + 6) @(posedge clk);
    #1;
  endtask : shot
endmodule : tsrm_host_model

// File: testbench/tsrm_regbank_tb_top.sv
// self-checking bench of the register bank
`timescale 1ns/10ps
module tsrm_regbank_tb_top;
  localparam int         CONV_TICKS = 8;
  localparam int         FAST_TICKS = 20;
  localparam logic [7:0] MAKER_ID   = 8'h5A;  // arbitrary value
  localparam logic [7:0] REVISION   = 8'h00;
  logic clk, srst, wrStb, rdStb, rdValid, diodeOpen, convStart, convBusy;
  logic alertOut_n, shutdown_out_n, v;
  logic [7:0] cmdCode, wrData, rdData, d;
  logic [10:0] localReading, remoteReading;
  int err_total, cmp_count, starts;
  tsrm_regbank #(.CONV_TICKS(CONV_TICKS), .FAST_TICKS(FAST_TICKS), .MAKER_ID(MAKER_ID),
    .REVISION(REVISION)) uut (.clk(clk), .srst(srst), .cmdCode(cmdCode), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rdValid(rdValid),
    .localReading(localReading), .remoteReading(remoteReading), .diodeOpen(diodeOpen),
    .convStart(convStart), .convBusy(convBusy), .alertOut_n(alertOut_n),
    .shutdown_out_n(shutdown_out_n));
  tsrm_host_model #(.CONV_TICKS(CONV_TICKS)) host (.clk(clk), .cmdCode(cmdCode),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rdValid(rdValid));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (convStart === 1'b1) starts++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask : check
  task automatic rdchk(input logic [7:0] c, input logic [7:0] m, input logic [7:0] exp);
    host.rd(c, d, v);
    check({7'h00, v}, 8'h01);
    check(d & m, exp);
  endtask : rdchk
  task automatic t_reset();
    logic [15:0] tbl [17] = '{16'h0408, 16'h0546, 16'h0600, 16'h0746, 16'h0800, 16'h1100,
      16'h1200, 16'h1300, 16'h1400, 16'h1955, 16'h2055, 16'h210A, 16'hBF00, 16'h0300,
      16'hFE5A, 16'hFF00, 16'h0FFF};
    repeat (150) @(posedge clk);
    #1;
    check({7'h00, starts >= 2}, 8'h01);
    rdchk(8'h02, 8'h7F, 8'h00);
    foreach (tbl[i]) rdchk(tbl[i][15:8], 8'hFF, tbl[i][7:0]);
  endtask : t_reset
  task automatic t_writes();
    logic [39:0] tbl [15] = '{40'h0AFF040F08, 40'h0B5C055C46, 40'h0511054646,
      40'h0D3B073B46, 40'h13FF13E000, 40'h0C81068100, 40'h0E92089200, 40'h14FF14E000,
      40'h197F197F55, 40'h2033203355, 40'h21FF211F0A, 40'h1112111200, 40'h12FF12E000,
      40'hBFFFBF0100, 40'h0302030000};
    foreach (tbl[i]) begin
      host.wr(tbl[i][39:32], tbl[i][31:24]);
      rdchk(tbl[i][23:16], 8'hFF, tbl[i][15:8]);
      host.wr(tbl[i][39:32], tbl[i][7:0]);
    end
  endtask : t_writes
  task automatic t_shot();
    int s0;
    s0 = starts;
    host.shot();
    repeat (300) @(posedge clk);
    check(8'(starts - s0), 8'h01);
  endtask : t_shot
  task automatic t_flags();
    localReading = 11'd561;
    remoteReading = 11'd700;
    diodeOpen = 1'b1;
    host.shot();
    check({7'h00, alertOut_n}, 8'h00);
    rdchk(8'h02, 8'hFF, 8'h56);
    check({7'h00, alertOut_n}, 8'h01);
    rdchk(8'h03, 8'hFF, 8'hC0);
    host.wr(8'hBF, 8'h01);
    host.wr(8'h09, 8'h40);
    localReading = 11'h7F8;
    remoteReading = 11'h7F8;
    diodeOpen = 1'b0;
    host.shot();
    rdchk(8'h02, 8'h7F, 8'h28);
    check({7'h00, alertOut_n}, 8'h00);
    localReading = 11'd200;
    remoteReading = 11'd200;
    host.shot();
    check({7'h00, alertOut_n}, 8'h01);
    host.wr(8'hBF, 8'h00);
    host.wr(8'h09, 8'hC0);
    localReading = 11'd561;
    host.shot();
    check({7'h00, alertOut_n}, 8'h01);
    localReading = 11'd200;
    host.wr(8'h09, 8'h40);
    host.rd(8'h02, d, v);
  endtask : t_flags
  task automatic t_shut();
    logic [7:0] setup [3] = '{8'h40, 8'h40, 8'h44};
    logic [10:0] rdg [3] = '{11'd700, 11'd200, 11'd700};
    logic [7:0] pin [3] = '{8'h00, 8'h01, 8'h01};
    foreach (rdg[i]) begin
      host.wr(8'h09, setup[i]);
      localReading = rdg[i];
      host.shot();
      check({7'h00, shutdown_out_n}, pin[i]);
    end
    localReading = 11'd200;
    host.wr(8'h09, 8'h41);
    host.rd(8'h02, d, v);
  endtask : t_shut
  task automatic t_queue();
    logic [7:0] flag [7] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [6:0] high = 7'b1110111;
    foreach (flag[i]) begin
      remoteReading = high[6 - i] ? 11'd576 : 11'd200;
      host.shot();
      rdchk(8'h02, 8'h10, flag[i]);
    end
  endtask : t_queue
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    err_total = 0;
    cmp_count = 0;
    starts = 0;
    srst = 1'b1;
    localReading = 11'd200;
    remoteReading = 11'd200;
    diodeOpen = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_writes();
    host.wr(8'h09, 8'h40);
    repeat (30) @(posedge clk);
    host.rd(8'h02, d, v);
    t_shot();
    t_flags();
    t_shut();
    t_queue();
    end_of_test();
  end
endmodule : tsrm_regbank_tb_top
bind tsrm_regbank tsrm_regbank_asserts #(.CONV_TICKS(CONV_TICKS), .MAKER_ID(MAKER_ID),
  .REVISION(REVISION)) u_chk (.clk(clk), .srst(srst), .cmdCode(cmdCode), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rdValid(rdValid),
  .localReading(localReading), .remoteReading(remoteReading), .diodeOpen(diodeOpen),
  .convStart(convStart), .convBusy(convBusy), .alertOut_n(alertOut_n),
  .shutdown_out_n(shutdown_out_n));
